// [core/mch_handler.sv]
`timescale 1ns/10ps
module mch_handler #(
    parameter int DATA_W = 32
) (
    input wire logic SYS_CLK_I,
    input wire logic RST_I,
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    output logic [31:0] HRDATA_O,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    input wire logic [DATA_W-1:0] PROCESS_VALUE_I,
    input wire logic [DATA_W-1:0] CMP_STATUS_I,
    input wire logic KEY_INIT_LEVEL_I,
    input wire logic CAL_LEVEL_I,
    input wire logic NVM_FAULT_I,
    input wire logic MEAS_FAULT_I,
    output logic SETTING_AREA1_O,
    output logic MEASURE_RUN_O,
    output logic LEVEL_IND_INIT_O,
    output logic PROTECT_LEVEL_O,
    output logic FORCED_ZERO_O,
    output logic SW_RESET_O,
    output logic [DATA_W-1:0] REMOTE_VALUE_O,
    output logic REMOTE_STROBE_O,
    output logic [DATA_W-1:0] CMP_ONE_VALUE_O,
    output logic [DATA_W-1:0] CMP_TWO_VALUE_O
);

    // ==================================================
    // Bus slave state
    mch_pkg::mch_bus_t bus_state;
    logic [7:0] bus_addr;
    logic [31:0] next_rdata;
    logic go;

    // ==================================================
    // Request and answer registers
    logic [15:0] req_codes, req_args, req_addr, req_count;
    logic [7:0] req_len;
    logic [31:0] req_data;
    logic exec, done;
    logic [15:0] resp_code, resp_echo;
    logic [31:0] resp_data;

    // ==================================================
    // Meter state
    logic area1, write_en, forced_zero, protect, sw_reset;
    logic [DATA_W-1:0] remote_value;
    logic remote_strobe;
    logic [DATA_W-1:0] cmp_value [mch_pkg::MCH_CMP_COUNT];

    // ==================================================
    // Decode results
    logic [7:0] instr, info, need_len;
    logic is_op, is_read, is_write;
    logic len_short, len_over, op_valid, op_refused;
    logic [15:0] next_result;
    logic [31:0] next_data;
    logic do_wen, do_fzero, do_reset, do_area1, do_protect, do_remote, do_cmp;
    logic [2:0] cmp_idx;

    assign instr = req_args[7:0];
    assign info = req_args[15:8];
    assign cmp_idx = 3'(req_addr[2:0] - 3'h1);

    // ==================================================
    // AHB-Lite slave: reads take one wait state so read data comes from a flop
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            bus_state <= mch_pkg::MCH_BUS_IDLE;
            bus_addr <= 8'h00;
        end else if (HREADY_I && bus_state != mch_pkg::MCH_BUS_RWAIT) begin
            bus_addr <= HADDR_I[7:0];
            if (HSEL_I && HTRANS_I[1]) begin
                bus_state <= HWRITE_I ? mch_pkg::MCH_BUS_WRITE : mch_pkg::MCH_BUS_RWAIT;
            end else begin
                bus_state <= mch_pkg::MCH_BUS_IDLE;
            end
        end else if (bus_state == mch_pkg::MCH_BUS_RWAIT) begin
            bus_state <= mch_pkg::MCH_BUS_ROUT;
        end
    end

    assign HREADYOUT_O = (bus_state != mch_pkg::MCH_BUS_RWAIT);
    assign HRESP_O = 1'b0;

    // Read mux; unmapped offsets read as zero
    always_comb begin
        unique case (bus_addr)
            mch_pkg::MCH_REG_CTRL: next_rdata = {31'h0000_0000, done};
            mch_pkg::MCH_REG_CODES: next_rdata = {16'h0000, req_codes};
            mch_pkg::MCH_REG_ARGS: next_rdata = {16'h0000, req_args};
            mch_pkg::MCH_REG_ADDR: next_rdata = {req_count, req_addr};
            mch_pkg::MCH_REG_LEN: next_rdata = {24'h00_0000, req_len};
            mch_pkg::MCH_REG_WDATA: next_rdata = req_data;
            mch_pkg::MCH_REG_RESP: next_rdata = {resp_code, resp_echo};
            mch_pkg::MCH_REG_RDATA: next_rdata = resp_data;
            mch_pkg::MCH_REG_STATUS: next_rdata = {26'h000_0000, CAL_LEVEL_I,
                ~area1, protect, forced_zero, write_en, area1};
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    // Read data captured in the wait cycle
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            HRDATA_O <= 32'h0000_0000;
        end else if (bus_state == mch_pkg::MCH_BUS_RWAIT) begin
            HRDATA_O <= next_rdata;
        end
    end

    // Request registers written in the write data phase
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            req_codes <= 16'h0000;
            req_args <= 16'h0000;
            req_addr <= 16'h0000;
            req_count <= 16'h0000;
            req_len <= 8'h00;
            req_data <= 32'h0000_0000;
            go <= 1'b0;
        end else begin
            go <= 1'b0;
            if (bus_state == mch_pkg::MCH_BUS_WRITE) begin
                unique case (bus_addr)
                    mch_pkg::MCH_REG_CTRL: go <= HWDATA_I[0];
                    mch_pkg::MCH_REG_CODES: req_codes <= HWDATA_I[15:0];
                    mch_pkg::MCH_REG_ARGS: req_args <= HWDATA_I[15:0];
                    mch_pkg::MCH_REG_ADDR: begin
                        req_addr <= HWDATA_I[15:0];
                        req_count <= HWDATA_I[31:16];
                    end
                    mch_pkg::MCH_REG_LEN: req_len <= HWDATA_I[7:0];
                    mch_pkg::MCH_REG_WDATA: req_data <= HWDATA_I;
                    default: ;
                endcase
            end
        end
    end

    // ==================================================
    // Command classification and length check
    always_comb begin
        is_op = (req_codes == {mch_pkg::MCH_MAIN_OP, mch_pkg::MCH_SUB_OP});
        is_read = (req_codes == {mch_pkg::MCH_MAIN_VAR, mch_pkg::MCH_SUB_READ});
        is_write = (req_codes == {mch_pkg::MCH_MAIN_VAR, mch_pkg::MCH_SUB_WRITE});
        if (is_op) begin
            need_len = mch_pkg::MCH_LEN_OP;
        end else if (is_read) begin
            need_len = mch_pkg::MCH_LEN_READ;
        end else begin
            need_len = mch_pkg::MCH_LEN_WRITE;
        end
        len_over = (req_len > need_len);
        len_short = (req_len < need_len);
    end

    // Instruction and related information must be one of the defined pairs
    always_comb begin
        unique case (instr)
            mch_pkg::MCH_INS_WRITE_EN, mch_pkg::MCH_INS_FZERO:
                op_valid = (info == mch_pkg::MCH_INFO_OFF) || (info == mch_pkg::MCH_INFO_ON);
            mch_pkg::MCH_INS_SW_RESET, mch_pkg::MCH_INS_AREA1, mch_pkg::MCH_INS_PROTECT:
                op_valid = (info == mch_pkg::MCH_INFO_OFF);
            default: op_valid = 1'b0;
        endcase
    end

    // Calibration, memory fault, disabled writing and area limits refuse the instruction
    assign op_refused = CAL_LEVEL_I || NVM_FAULT_I
        || (instr != mch_pkg::MCH_INS_WRITE_EN && !write_en)
        || (instr == mch_pkg::MCH_INS_FZERO && (area1 || MEAS_FAULT_I))
        || (instr == mch_pkg::MCH_INS_PROTECT && area1);

    // ==================================================
    // Command execution decode
    always_comb begin
        next_result = mch_pkg::MCH_RES_OK;
        next_data = 32'h0000_0000;
        do_wen = 1'b0;
        do_fzero = 1'b0;
        do_reset = 1'b0;
        do_area1 = 1'b0;
        do_protect = 1'b0;
        do_remote = 1'b0;
        do_cmp = 1'b0;
        if (!(is_op || is_read || is_write)) begin
            next_result = mch_pkg::MCH_RES_PARAM;
        end else if (len_over) begin
            next_result = mch_pkg::MCH_RES_LONG;
        end else if (len_short) begin
            next_result = mch_pkg::MCH_RES_SHORT;
        end else if (is_op) begin
            if (!op_valid) begin
                next_result = mch_pkg::MCH_RES_PARAM;
            end else if (op_refused) begin
                next_result = mch_pkg::MCH_RES_OPER;
            end else begin
                unique case (instr)
                    mch_pkg::MCH_INS_WRITE_EN: do_wen = 1'b1;
                    mch_pkg::MCH_INS_FZERO: do_fzero = 1'b1;
                    mch_pkg::MCH_INS_SW_RESET: do_reset = 1'b1;
                    mch_pkg::MCH_INS_AREA1: do_area1 = 1'b1;
                    default: do_protect = 1'b1;
                endcase
            end
        end else if (req_args[15:8] != mch_pkg::MCH_BITPOS
                     || req_count != mch_pkg::MCH_ONE_ELEMENT) begin
            next_result = mch_pkg::MCH_RES_PARAM;
        end else if (is_read) begin
            // Reads are served in both areas
            if (instr == mch_pkg::MCH_AREA_C0) begin
                if (req_addr == mch_pkg::MCH_ADR_PV) begin
                    next_data = area1 ? mch_pkg::MCH_UNKNOWN : 32'(PROCESS_VALUE_I);
                end else if (req_addr == mch_pkg::MCH_ADR_STATUS) begin
                    next_data = area1 ? mch_pkg::MCH_UNKNOWN : 32'(CMP_STATUS_I);
                end else begin
                    next_result = mch_pkg::MCH_RES_ADDR;
                end
            end else if (instr == mch_pkg::MCH_AREA_C2) begin
                if (req_addr == mch_pkg::MCH_ADR_REMOTE) begin
                    next_data = 32'(remote_value);
                end else if (req_addr <= mch_pkg::MCH_ADR_CMP_LAST) begin
                    next_data = 32'(cmp_value[cmp_idx]);
                end else begin
                    next_result = mch_pkg::MCH_RES_ADDR;
                end
            end else begin
                next_result = mch_pkg::MCH_RES_AREA;
            end
        end else begin
            // Setting-level areas belong to another block, so only C0 and C2 are known here
            if (instr == mch_pkg::MCH_AREA_C0) begin
                next_result = mch_pkg::MCH_RES_RDONLY;
            end else if (instr != mch_pkg::MCH_AREA_C2) begin
                next_result = mch_pkg::MCH_RES_AREA;
            end else if (req_addr > mch_pkg::MCH_ADR_CMP_LAST) begin
                next_result = mch_pkg::MCH_RES_ADDR;
            end else if (CAL_LEVEL_I || NVM_FAULT_I || !write_en) begin
                next_result = mch_pkg::MCH_RES_OPER;
            end else if (req_addr == mch_pkg::MCH_ADR_REMOTE) begin
                do_remote = !area1;
            end else begin
                do_cmp = 1'b1;
            end
        end
    end

    // ==================================================
    // Execution strobe and answer
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            exec <= 1'b0;
            done <= 1'b0;
            resp_code <= mch_pkg::MCH_RES_OK;
            resp_echo <= 16'h0000;
            resp_data <= 32'h0000_0000;
        end else begin
            exec <= go;
            // Completion wins over a new start in the same cycle
            if (exec) begin
                done <= 1'b1;
                resp_code <= next_result;
                resp_echo <= req_codes;
                resp_data <= next_data;
            end else if (go) begin
                done <= 1'b0;
            end
        end
    end

    // ==================================================
    // Setting area and level state
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            area1 <= 1'b0;
            protect <= 1'b0;
            sw_reset <= 1'b0;
        end else begin
            sw_reset <= exec && do_reset;
            if (KEY_INIT_LEVEL_I) begin
                area1 <= 1'b1;
                protect <= 1'b0;
            end else if (exec && do_reset) begin
                area1 <= 1'b0;
                protect <= 1'b0;
            end else if (exec && do_area1) begin
                area1 <= 1'b1;
                protect <= 1'b0;
            end else if (exec && do_protect) begin
                protect <= 1'b1;
            end
        end
    end

    // Writing permission and forced zero
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            write_en <= 1'b0;
            forced_zero <= 1'b0;
        end else if (exec) begin
            if (do_wen) begin
                write_en <= (info == mch_pkg::MCH_INFO_ON);
            end
            if (do_fzero) begin
                forced_zero <= (info == mch_pkg::MCH_INFO_ON);
            end else if (do_reset) begin
                forced_zero <= 1'b0;
            end
        end
    end

    // Remote display value and comparison settings
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            remote_value <= DATA_W'(mch_pkg::MCH_VALUE_RST);
            remote_strobe <= 1'b0;
            for (int i = 0; i < mch_pkg::MCH_CMP_COUNT; i++) begin
                cmp_value[i] <= DATA_W'(mch_pkg::MCH_VALUE_RST);
            end
        end else begin
            remote_strobe <= exec && do_remote;
            if (exec && do_remote) begin
                remote_value <= DATA_W'(req_data);
            end
            if (exec && do_cmp) begin
                cmp_value[cmp_idx] <= DATA_W'(req_data);
            end
        end
    end

    // ==================================================
    // Outputs; measuring stops whenever area 1 is entered
    assign SETTING_AREA1_O = area1;
    assign MEASURE_RUN_O = ~area1;
    assign LEVEL_IND_INIT_O = area1;
    assign PROTECT_LEVEL_O = protect;
    assign FORCED_ZERO_O = forced_zero;
    assign SW_RESET_O = sw_reset;
    assign REMOTE_VALUE_O = remote_value;
    assign REMOTE_STROBE_O = remote_strobe;
    assign CMP_ONE_VALUE_O = cmp_value[0];
    assign CMP_TWO_VALUE_O = cmp_value[3];

    // ==================================================
    // Checks
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (RST_I);

    area_after_reset_a: assert property (@(posedge SYS_CLK_I) disable iff (1'b0)
        RST_I |=> !SETTING_AREA1_O && MEASURE_RUN_O) else $error("not area 0 after reset");
    enter_area_one_a: assert property (
        exec && is_op && !len_over && !len_short && instr == mch_pkg::MCH_INS_AREA1
        && info == mch_pkg::MCH_INFO_OFF && write_en && !CAL_LEVEL_I && !NVM_FAULT_I
        |=> SETTING_AREA1_O && LEVEL_IND_INIT_O && resp_code == mch_pkg::MCH_RES_OK)
        else $error("area 1 not entered");
    leave_area_one_a: assert property (
        $fell(area1) |-> (sw_reset && $past(exec)) || $past(RST_I))
        else $error("area 1 left wrongly");
    bad_param_a: assert property (
        exec && is_op && !len_over && !len_short && !op_valid
        |=> resp_code == mch_pkg::MCH_RES_PARAM && $stable(area1) && $stable(write_en)
        && !SW_RESET_O) else $error("invalid instruction acted");
    short_frame_a: assert property (
        exec && is_op && len_short |=> resp_code == mch_pkg::MCH_RES_SHORT && done)
        else $error("short frame not flagged");
    long_frame_a: assert property (
        exec && is_op && len_over |=> resp_code == mch_pkg::MCH_RES_LONG)
        else $error("long frame not flagged");
    write_refused_a: assert property (
        exec && is_op && !len_over && !len_short && op_valid && !write_en
        && instr != mch_pkg::MCH_INS_WRITE_EN |=> resp_code == mch_pkg::MCH_RES_OPER)
        else $error("disabled write accepted");
    calibration_block_a: assert property (
        exec && CAL_LEVEL_I && is_op && !len_over && !len_short && op_valid
        |=> resp_code == mch_pkg::MCH_RES_OPER && $stable(area1)) else $error("cal not refused");
    pv_unknown_a: assert property (
        exec && next_result == mch_pkg::MCH_RES_OK && is_read && area1
        && instr == mch_pkg::MCH_AREA_C0 |=> resp_data == mch_pkg::MCH_UNKNOWN)
        else $error("value not unknown in area 1");
    echo_codes_a: assert property (
        exec |=> resp_echo == $past(req_codes)) else $error("codes not echoed");
    key_entry_a: assert property (
        KEY_INIT_LEVEL_I |=> area1 ##1 (area1 || SW_RESET_O)) else $error("key entry lost");

    area_one_c: cover property (exec && do_area1 ##1 area1);
    reset_back_c: cover property (area1 ##1 SW_RESET_O && !area1);
    fzero_c: cover property (exec && do_fzero ##1 FORCED_ZERO_O);
    refused_c: cover property (exec ##1 resp_code == mch_pkg::MCH_RES_OPER);

endmodule

// [core/mch_pkg.sv]
package mch_pkg;

    // ==================================================
    // Register map (byte offsets)
    localparam logic [7:0] MCH_REG_CTRL = 8'h00;
    localparam logic [7:0] MCH_REG_CODES = 8'h04;
    localparam logic [7:0] MCH_REG_ARGS = 8'h08;
    localparam logic [7:0] MCH_REG_ADDR = 8'h0c;
    localparam logic [7:0] MCH_REG_LEN = 8'h10;
    localparam logic [7:0] MCH_REG_WDATA = 8'h14;
    localparam logic [7:0] MCH_REG_RESP = 8'h18;
    localparam logic [7:0] MCH_REG_RDATA = 8'h1c;
    localparam logic [7:0] MCH_REG_STATUS = 8'h20;

    // ==================================================
    // Service codes
    localparam logic [7:0] MCH_MAIN_VAR = 8'h01;
    localparam logic [7:0] MCH_SUB_READ = 8'h01;
    localparam logic [7:0] MCH_SUB_WRITE = 8'h02;
    localparam logic [7:0] MCH_MAIN_OP = 8'h30;
    localparam logic [7:0] MCH_SUB_OP = 8'h05;
    localparam logic [7:0] MCH_INS_WRITE_EN = 8'h00;
    localparam logic [7:0] MCH_INS_FZERO = 8'h03;
    localparam logic [7:0] MCH_INS_SW_RESET = 8'h06;
    localparam logic [7:0] MCH_INS_AREA1 = 8'h07;
    localparam logic [7:0] MCH_INS_PROTECT = 8'h08;
    localparam logic [7:0] MCH_INFO_OFF = 8'h00;
    localparam logic [7:0] MCH_INFO_ON = 8'h01;
    localparam logic [7:0] MCH_AREA_C0 = 8'hc0;
    localparam logic [7:0] MCH_AREA_C2 = 8'hc2;
    localparam logic [15:0] MCH_ADR_REMOTE = 16'h0000;
    localparam logic [15:0] MCH_ADR_PV = 16'h0001;
    localparam logic [15:0] MCH_ADR_STATUS = 16'h0002;
    localparam logic [15:0] MCH_ADR_CMP_LAST = 16'h0006;
    localparam logic [7:0] MCH_BITPOS = 8'h00;
    localparam logic [15:0] MCH_ONE_ELEMENT = 16'h0001;

    // ==================================================
    // Defined command text lengths in characters
    localparam logic [7:0] MCH_LEN_OP = 8'd8;
    localparam logic [7:0] MCH_LEN_READ = 8'd16;
    localparam logic [7:0] MCH_LEN_WRITE = 8'd24;

    // ==================================================
    // Result codes
    localparam logic [15:0] MCH_RES_OK = 16'h0000;
    localparam logic [15:0] MCH_RES_LONG = 16'h1001;
    localparam logic [15:0] MCH_RES_SHORT = 16'h1002;
    localparam logic [15:0] MCH_RES_PARAM = 16'h1100;
    localparam logic [15:0] MCH_RES_AREA = 16'h1101;
    localparam logic [15:0] MCH_RES_ADDR = 16'h1103;
    localparam logic [15:0] MCH_RES_OPER = 16'h2203;
    localparam logic [15:0] MCH_RES_RDONLY = 16'h3003;

    // ==================================================
    // Reset value, unknown-value marker and comparison count
    localparam logic [31:0] MCH_UNKNOWN = 32'hffff_ffff;
    localparam logic [31:0] MCH_VALUE_RST = 32'h0000_0000;
    localparam int MCH_CMP_COUNT = 6;

    typedef enum logic [1:0] {
        MCH_BUS_IDLE,
        MCH_BUS_WRITE,
        MCH_BUS_RWAIT,
        MCH_BUS_ROUT
    } mch_bus_t;

endpackage

// [testbench/mch_host.sv]
`timescale 1ns/10ps
// ==================================================
// Host side: single-word bus master that frames the meter's requests
module mch_host (
    input wire logic clk_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_i,
    output logic hsel_o,
    output logic [31:0] haddr_o,
    output logic [1:0] htrans_o,
    output logic hwrite_o,
    output logic [2:0] hsize_o,
    output logic [31:0] hwdata_o
);
    // Bus idle until the first request
    initial begin
        hsel_o = 1'b0;
        haddr_o = 32'h0;
        htrans_o = 2'h0;
        hwrite_o = 1'b0;
        hsize_o = 3'h2;
        hwdata_o = 32'h0;
    end
    // Entered just after a rising edge; each phase held until ready is seen high
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        hsel_o <= 1'b1;
        htrans_o <= 2'h2;
        hwrite_o <= w;
        haddr_o <= {24'h0, a};
        do @(posedge clk_i); while (hready_i !== 1'b1);
        htrans_o <= 2'h0;
        hwdata_o <= d;
        do @(posedge clk_i); while (hready_i !== 1'b1);
        q = hrdata_i;
        hwdata_o <= ~d; // Released data never shows the old word
    endtask
endmodule

// [testbench/test_mch_handler.sv]
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
    $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
`define OP(g, r, s) '{3'h0, 16'h3005, g, 16'h0000, 8'h08, 32'h0, r, s}
`define RD(g, a, d, s) '{3'h0, 16'h0101, g, a, 8'h10, d, 16'h0000, s}
module test_mch_handler;
    typedef struct {logic [2:0] f; logic [15:0] c; logic [15:0] g; logic [15:0] a;
        logic [7:0] l; logic [31:0] d; logic [15:0] r; logic [5:0] s;} mch_row_t;
    logic clk = 1'b0, rst = 1'b1, key = 1'b0, cal = 1'b0, nvm = 1'b0, meas = 1'b0;
    logic hsel, hwrite, hready, hresp, area1, run, ind, prot, fz, swr, rstb;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rem, c1, c2, rq;
    int fail_count = 0, comparisons = 0, cycles = 0, swr_n = 0, stb_n = 0;
    // Faults, codes, info, address, length, data, result, status
    mch_row_t rows [25] = '{`OP(16'h0100, 16'h0000, 6'h12),
        '{3'h0, 16'h3005, 16'h0100, 16'h0000, 8'h09, 32'h0, 16'h1001, 6'h12},
        '{3'h0, 16'h3005, 16'h0100, 16'h0000, 8'h07, 32'h0, 16'h1002, 6'h12},
        `OP(16'h0009, 16'h1100, 6'h12), `OP(16'h0207, 16'h1100, 6'h12),
        `OP(16'h0103, 16'h0000, 6'h16), `OP(16'h0003, 16'h0000, 6'h12),
        `OP(16'h0008, 16'h0000, 6'h1a), `RD(16'h00c0, 16'h0001, 32'h1234, 6'h1a),
        '{3'h0, 16'h0102, 16'h00c2, 16'h0001, 8'h18, 32'h0abc, 16'h0000, 6'h1a},
        `RD(16'h00c0, 16'h0002, 32'h0055, 6'h1a),
        '{3'h0, 16'h0102, 16'h00c2, 16'h0004, 8'h18, 32'h0def, 16'h0000, 6'h1a},
        `OP(16'h0007, 16'h0000, 6'h03),
        `RD(16'h00c0, 16'h0001, 32'hffffffff, 6'h03),
        `RD(16'h00c0, 16'h0002, 32'hffffffff, 6'h03),
        `RD(16'h00c2, 16'h0001, 32'h0abc, 6'h03), `OP(16'h0103, 16'h2203, 6'h03),
        '{3'h0, 16'h0102, 16'h00c2, 16'h0000, 8'h18, 32'h5a5a, 16'h0000, 6'h03},
        `OP(16'h0006, 16'h0000, 6'h12), `OP(16'h0000, 16'h0000, 6'h10),
        `OP(16'h0103, 16'h2203, 6'h10), `OP(16'h0100, 16'h0000, 6'h12),
        '{3'h4, 16'h3005, 16'h0003, 16'h0000, 8'h08, 32'h0, 16'h2203, 6'h32},
        '{3'h2, 16'h3005, 16'h0003, 16'h0000, 8'h08, 32'h0, 16'h2203, 6'h12},
        '{3'h1, 16'h3005, 16'h0103, 16'h0000, 8'h08, 32'h0, 16'h2203, 6'h12}};
    mch_host mch_host_inst (.clk_i(clk), .hready_i(hready), .hrdata_i(hrdata), .hsel_o(hsel),
        .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite), .hsize_o(hsize),
        .hwdata_o(hwdata));
    mch_handler mch_handler_inst (.SYS_CLK_I(clk), .RST_I(rst), .HSEL_I(hsel), .HADDR_I(haddr),
        .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata),
        .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
        .PROCESS_VALUE_I(32'h1234), .CMP_STATUS_I(32'h0055), .KEY_INIT_LEVEL_I(key),
        .CAL_LEVEL_I(cal), .NVM_FAULT_I(nvm), .MEAS_FAULT_I(meas), .SETTING_AREA1_O(area1),
        .MEASURE_RUN_O(run), .LEVEL_IND_INIT_O(ind), .PROTECT_LEVEL_O(prot), .FORCED_ZERO_O(fz),
        .SW_RESET_O(swr), .REMOTE_VALUE_O(rem), .REMOTE_STROBE_O(rstb), .CMP_ONE_VALUE_O(c1),
        .CMP_TWO_VALUE_O(c2));
    // ==================================================
    // Clock and hang guard; a full run takes well under a thousand cycles
    initial begin
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            wrap_up();
        end
    end
    // Count one-cycle pulses at the falling edge, where they have settled
    always @(negedge clk) begin
        swr_n += (swr === 1'b1);
        stb_n += (rstb === 1'b1);
    end
    task automatic wrap_up();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Load request words, start, then check answer, data and state
    task automatic cmd(input mch_row_t w);
        logic [31:0] q;
        {cal, nvm, meas} <= w.f;
        mch_host_inst.xfer(1'b1, mch_pkg::MCH_REG_CODES, {16'h0, w.c}, q);
        mch_host_inst.xfer(1'b1, mch_pkg::MCH_REG_ARGS, {16'h0, w.g}, q);
        mch_host_inst.xfer(1'b1, mch_pkg::MCH_REG_ADDR, {16'h0001, w.a}, q);
        mch_host_inst.xfer(1'b1, mch_pkg::MCH_REG_LEN, {24'h0, w.l}, q);
        mch_host_inst.xfer(1'b1, mch_pkg::MCH_REG_WDATA, w.d, q);
        mch_host_inst.xfer(1'b1, mch_pkg::MCH_REG_CTRL, 32'h1, q);
        // The answer lands on the edge that captures a read issued right away, so poll done
        do mch_host_inst.xfer(1'b0, mch_pkg::MCH_REG_CTRL, 32'h0, q);
        while (q[0] !== 1'b1);
        mch_host_inst.xfer(1'b0, mch_pkg::MCH_REG_RESP, 32'h0, q);
        `CHK(q, {w.r, w.c})
        if (w.c == 16'h0101) begin
            mch_host_inst.xfer(1'b0, mch_pkg::MCH_REG_RDATA, 32'h0, q);
            `CHK(q, w.d)
        end
        mch_host_inst.xfer(1'b0, mch_pkg::MCH_REG_STATUS, 32'h0, q);
        `CHK(q, {26'h0, w.s})
        `CHK({prot, fz, hresp}, {w.s[3], w.s[2], 1'b0})
    endtask
    // ==================================================
    // Main sequence
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        `CHK({run, area1, ind}, 3'b100)
        foreach (rows[i]) cmd(rows[i]);
        `CHK(rem, 32'h0)
        `CHK(c1, 32'h0abc)
        cmd('{3'h0, 16'h0102, 16'h00c2, 16'h0000, 8'h18, 32'h5a5a, 16'h0000, 6'h12});
        `CHK(rem, 32'h5a5a)
        key <= 1'b1;
        @(posedge clk);
        key <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK({area1, ind, run}, 3'b110)
        `CHK(c2, 32'h0def)
        `CHK(swr_n, 1)
        `CHK(stb_n, 1)
        // Mid-run reset brings area 0 back and drops writing permission
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        `CHK({run, area1, ind}, 3'b100)
        mch_host_inst.xfer(1'b0, mch_pkg::MCH_REG_STATUS, 32'h0, rq);
        `CHK(rq, 32'h0000_0010)
        wrap_up();
    end
endmodule
